// ### hw/cts_pkg.sv
// constants and types of the cluster time base
package cts_pkg;
   localparam int CTS_CW = 6;
   localparam int CTS_MW = 14;
   localparam int CTS_UW = 20;
   localparam int CTS_DW = 16;
   localparam int CTS_PW = 8;

   localparam logic [7:0] CTS_REG_CTRL   = 8'h00;
   localparam logic [7:0] CTS_REG_CYCMAX = 8'h04;
   localparam logic [7:0] CTS_REG_MACROS = 8'h08;
   localparam logic [7:0] CTS_REG_MICROS = 8'h0c;
   localparam logic [7:0] CTS_REG_OFSSTA = 8'h10;
   localparam logic [7:0] CTS_REG_NITSTA = 8'h14;
   localparam logic [7:0] CTS_REG_OFSLIM = 8'h18;
   localparam logic [7:0] CTS_REG_RATLIM = 8'h1c;
   localparam logic [7:0] CTS_REG_TIME   = 8'h20;
   localparam logic [7:0] CTS_REG_MICRO  = 8'h24;
   localparam logic [7:0] CTS_REG_FIX    = 8'h28;
   localparam logic [7:0] CTS_REG_STATUS = 8'h2c;

   localparam int CTS_CTRL_RUN_BIT   = 0;
   localparam int CTS_CTRL_MODE_LSB  = 1;
   localparam int CTS_CTRL_PRESC_LSB = 8;
   localparam int CTS_TIME_CYC_LSB   = 16;
   localparam int CTS_FIX_RATE_LSB   = 16;

   localparam logic [7:0]  CTS_PRESC_RST  = 8'h00;
   localparam logic [7:0]  CTS_CYCMAX_RST = 8'h3f;
   localparam logic [15:0] CTS_MACROS_RST = 16'h0064;
   localparam logic [23:0] CTS_MICROS_RST = 24'h001770;
   localparam logic [15:0] CTS_OFSSTA_RST = 16'h005a;
   localparam logic [15:0] CTS_NITSTA_RST = 16'h0050;
   localparam logic [15:0] CTS_LIMIT_RST  = 16'h0040;

   typedef enum logic [1:0] {
      CTS_MODE_STANDBY = 2'b00,
      CTS_MODE_EXCLUDE = 2'b01,
      CTS_MODE_INCLUDE = 2'b10
   } cts_mode_e;

   typedef enum logic [1:0] {
      CTS_RES_WITHIN  = 2'b00,
      CTS_RES_EXCEEDS = 2'b01,
      CTS_RES_MISSING = 2'b10
   } cts_result_e;
endpackage

// ### hw/cts_timebase.sv
// macrotick generation and clock correction of one cluster node
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// [RQ1] cycle count rises by one at every cycle start
// [RQ2] cycle count wraps to zero after the configured maximum
// [RQ3] macro count runs zero to macros per cycle minus one
// [RQ4] cycle and macro counts change together on the same edge
// [RQ5] cycle and macro counts are readable in one register word
// [RQ6] each macrotick is whole microticks; lengths vary to spread fractions
// [RQ7] microticks come from the clock through a programmable prescaler
// [RQ8] macros per cycle is one fixed setting shared by all nodes
// [RQ9] every node corrects rate and offset by the same method
// [RQ10] rate correction is spread over the whole cycle
// [RQ11] offset correction only in odd idle time, from its start macrotick
// [RQ12] signed offset value stretches or shrinks the idle time
// [RQ13] offset computed every cycle, applied only in odd cycles
// [RQ14] offset result and ready shown only at idle time start
// [RQ15] signed rate value adds to nominal microticks per cycle
// [RQ16] rate computed once per double cycle from both cycles
// [RQ17] rate result shown at idle time, in force from next even cycle
// [RQ18] tick generator and sync compute process are separate parts
// [RQ19] software sets cycle max, macros per cycle and micros per cycle
// [RQ20] modes: standby halts the sync process, exclude or include own clock
// [RQ21] reset clears counters and corrections until timing starts
module cts_timebase
   import cts_pkg::*;
#(
   parameter int CW = CTS_CW,
   parameter int MW = CTS_MW,
   parameter int UW = CTS_UW,
   parameter int DW = CTS_DW,
   parameter int PW = CTS_PW
)
(
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   input  wire logic                 dev_valid,
   input  wire logic signed [DW-1:0] dev_value,
   output logic                      micro_tick,
   output logic                      macro_tick,
   output logic                      cycle_start,
   output logic [CW-1:0]             cycle_count,
   output logic [MW-1:0]             macro_count,
   output logic                      offset_ready,
   output logic                      rate_ready,
   output logic [1:0]                sync_result
);

   logic                 run_r;
   cts_mode_e            mode_r;
   logic [PW-1:0]        presc_r;
   logic [CW-1:0]        cycle_count_limit_r;
   logic [MW-1:0]        macros_in_cycle_r;
   logic [UW-1:0]        nominal_micros_in_cycle_r;
   logic [MW-1:0]        offset_fix_start_r;
   logic [MW-1:0]        nit_start_r;
   logic [DW-1:0]        offset_limit_r;
   logic [DW-1:0]        rate_limit_r;
   logic [PW-1:0]        presc_cnt_r;
   logic [UW-1:0]        micro_count;
   logic [UW:0]          acc_r;
   logic signed [DW-1:0] ofs_left_r;
   logic signed [DW-1:0] offset_fix_value;
   logic signed [DW-1:0] rate_fix_value;
   logic signed [DW-1:0] rate_pending_r;
   logic signed [DW-1:0] dev_min_r;
   logic signed [DW-1:0] dev_max_r;
   logic signed [DW-1:0] even_mid_r;
   logic                 have_r;
   logic                 even_have_r;
   logic                 meas_open_r;
   logic [31:0]          rd_nxt;
   logic [UW:0]          total;
   logic [UW:0]          step;
   logic [UW:0]          sum;
   logic                 tick_now;
   logic                 last;
   logic [MW-1:0]        macro_nxt;
   logic                 odd;
   logic                 csp_on;
   logic                 nit_now;
   logic signed [DW:0]   mid_sum;
   logic signed [DW-1:0] mid;
   logic signed [DW-1:0] off_calc;
   logic signed [DW-1:0] rate_calc;
   logic                 off_bad;
   logic                 rate_bad;

   function automatic logic beyond(input logic signed [DW-1:0] v,
                                   input logic [DW-1:0] lim);
      logic [DW-1:0] mag;
      mag = v[DW-1] ? DW'(-v) : DW'(v);
      return mag > lim;
   endfunction

   // register bus: writes
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         run_r                     <= 1'b0;
         mode_r                    <= CTS_MODE_STANDBY;
         presc_r                   <= PW'(CTS_PRESC_RST);
         cycle_count_limit_r       <= CW'(CTS_CYCMAX_RST);
         macros_in_cycle_r         <= MW'(CTS_MACROS_RST);
         nominal_micros_in_cycle_r <= UW'(CTS_MICROS_RST);
         offset_fix_start_r        <= MW'(CTS_OFSSTA_RST);
         nit_start_r               <= MW'(CTS_NITSTA_RST);
         offset_limit_r            <= DW'(CTS_LIMIT_RST);
         rate_limit_r              <= DW'(CTS_LIMIT_RST);
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            CTS_REG_CTRL:
            begin
               run_r   <= reg_wdata[CTS_CTRL_RUN_BIT];
               // code 11 is not a mode; it parks the sync process
               mode_r  <= (reg_wdata[CTS_CTRL_MODE_LSB +: 2] == 2'b11) ? CTS_MODE_STANDBY
                          : cts_mode_e'(reg_wdata[CTS_CTRL_MODE_LSB +: 2]); // see [RQ20]
               presc_r <= reg_wdata[CTS_CTRL_PRESC_LSB +: PW];
            end
            CTS_REG_CYCMAX: cycle_count_limit_r       <= reg_wdata[CW-1:0]; // see [RQ19]
            CTS_REG_MACROS: macros_in_cycle_r         <= reg_wdata[MW-1:0]; // see [RQ8]
            CTS_REG_MICROS: nominal_micros_in_cycle_r <= reg_wdata[UW-1:0];
            CTS_REG_OFSSTA: offset_fix_start_r        <= reg_wdata[MW-1:0];
            CTS_REG_NITSTA: nit_start_r               <= reg_wdata[MW-1:0];
            CTS_REG_OFSLIM: offset_limit_r            <= reg_wdata[DW-1:0];
            CTS_REG_RATLIM: rate_limit_r              <= reg_wdata[DW-1:0];
            default: ;
         endcase
      end
   end

   // register bus: read mux, unmapped reads give zero
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      case (reg_addr)
         CTS_REG_CTRL:
         begin
            rd_nxt[CTS_CTRL_RUN_BIT]           = run_r;
            rd_nxt[CTS_CTRL_MODE_LSB +: 2]     = mode_r;
            rd_nxt[CTS_CTRL_PRESC_LSB +: PW]   = presc_r;
         end
         CTS_REG_CYCMAX: rd_nxt[CW-1:0] = cycle_count_limit_r;
         CTS_REG_MACROS: rd_nxt[MW-1:0] = macros_in_cycle_r;
         CTS_REG_MICROS: rd_nxt[UW-1:0] = nominal_micros_in_cycle_r;
         CTS_REG_OFSSTA: rd_nxt[MW-1:0] = offset_fix_start_r;
         CTS_REG_NITSTA: rd_nxt[MW-1:0] = nit_start_r;
         CTS_REG_OFSLIM: rd_nxt[DW-1:0] = offset_limit_r;
         CTS_REG_RATLIM: rd_nxt[DW-1:0] = rate_limit_r;
         CTS_REG_TIME:
         begin
            // one word, so software never sees a torn cycle/macro pair
            rd_nxt[MW-1:0]                  = macro_count; // see [RQ5]
            rd_nxt[CTS_TIME_CYC_LSB +: CW]  = cycle_count; // see [RQ5]
         end
         CTS_REG_MICRO: rd_nxt[UW-1:0] = micro_count;
         CTS_REG_FIX:
         begin
            rd_nxt[DW-1:0]                  = offset_fix_value;
            rd_nxt[CTS_FIX_RATE_LSB +: DW]  = rate_fix_value;
         end
         CTS_REG_STATUS: rd_nxt[1:0] = sync_result;
         default: ;
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
         reg_rdata <= rd_nxt;
      else
         reg_rdata <= 32'h0000_0000;
   end

   // microtick prescaler, 0 means one microtick per clock
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         presc_cnt_r <= '0;
         micro_tick  <= 1'b0;
      end
      else if (!run_r)
      begin
         presc_cnt_r <= '0;
         micro_tick  <= 1'b0;
      end
      else if (presc_cnt_r >= presc_r)
      begin
         presc_cnt_r <= '0;
         micro_tick  <= 1'b1; // see [RQ7]
      end
      else
      begin
         presc_cnt_r <= presc_cnt_r + 1'b1;
         micro_tick  <= 1'b0;
      end
   end

   // tick generator: bresenham spread of corrected micros over macros
   always_comb
   begin
      total = {1'b0, nominal_micros_in_cycle_r}
            + {{(UW+1-DW){rate_fix_value[DW-1]}}, rate_fix_value}; // see [RQ15] [RQ10]
      // stall stretches idle time, double step shrinks it
      if (ofs_left_r > 0)
         step = '0; // see [RQ12]
      else if (ofs_left_r < 0)
         step = (UW+1)'({macros_in_cycle_r, 1'b0}); // see [RQ12]
      else
         step = (UW+1)'(macros_in_cycle_r);
      sum       = acc_r + step;
      tick_now  = micro_tick && (sum >= total); // see [RQ6]
      last      = (macro_count == macros_in_cycle_r - 1'b1);
      macro_nxt = last ? '0 : macro_count + 1'b1; // see [RQ3]
      odd       = cycle_count[0];
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         acc_r       <= '0;
         micro_count <= '0;
         macro_count <= '0;
         cycle_count <= '0;
         macro_tick  <= 1'b0;
         cycle_start <= 1'b0;
      end
      else if (!run_r)
      begin
         acc_r       <= '0; // see [RQ21]
         micro_count <= '0;
         macro_count <= '0;
         cycle_count <= '0;
         macro_tick  <= 1'b0;
         cycle_start <= 1'b0;
      end
      else
      begin
         macro_tick  <= tick_now;
         cycle_start <= tick_now && last;
         if (micro_tick)
         begin
            micro_count <= micro_count + 1'b1;
            acc_r       <= tick_now ? sum - total : sum;
         end
         if (tick_now)
         begin
            macro_count <= macro_nxt; // see [RQ4] [RQ18]
            if (last)
               cycle_count <= (cycle_count == cycle_count_limit_r) ? '0 // see [RQ2]
                              : cycle_count + 1'b1; // see [RQ1] [RQ4]
         end
      end
   end

   // offset phase: loaded at its start macrotick of odd cycles only
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         ofs_left_r <= '0;
      else if (!run_r || (tick_now && last))
         ofs_left_r <= '0; // see [RQ11]
      else if (tick_now && odd && macro_nxt == offset_fix_start_r)
         ofs_left_r <= offset_fix_value; // see [RQ11] [RQ13]
      else if (micro_tick && ofs_left_r > 0)
         ofs_left_r <= ofs_left_r - 1'b1;
      else if (micro_tick && ofs_left_r < 0)
         ofs_left_r <= ofs_left_r + 1'b1;
   end

   // sync compute process: midpoint of the cycle's deviations
   always_comb
   begin
      csp_on    = run_r && (mode_r != CTS_MODE_STANDBY); // see [RQ20]
      nit_now   = csp_on && tick_now && !last && (macro_nxt == nit_start_r);
      mid_sum   = {dev_min_r[DW-1], dev_min_r} + {dev_max_r[DW-1], dev_max_r};
      mid       = mid_sum[DW:1];
      off_calc  = DW'(-mid); // see [RQ9]
      rate_calc = DW'(rate_fix_value - (mid - even_mid_r)); // see [RQ16]
      off_bad   = beyond(off_calc, offset_limit_r);
      rate_bad  = beyond(rate_calc, rate_limit_r);
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dev_min_r   <= '0;
         dev_max_r   <= '0;
         have_r      <= 1'b0;
         meas_open_r <= 1'b0;
      end
      else if (!csp_on)
      begin
         have_r      <= 1'b0;
         meas_open_r <= 1'b0;
      end
      else if (tick_now && last)
      begin
         // include mode seeds the set with our own zero deviation
         dev_min_r   <= '0;
         dev_max_r   <= '0;
         have_r      <= (mode_r == CTS_MODE_INCLUDE); // see [RQ20]
         meas_open_r <= 1'b1;
      end
      else if (nit_now)
         meas_open_r <= 1'b0;
      else if (meas_open_r && dev_valid)
      begin
         have_r <= 1'b1;
         if (!have_r || dev_value < dev_min_r)
            dev_min_r <= dev_value;
         if (!have_r || dev_value > dev_max_r)
            dev_max_r <= dev_value;
      end
   end

   // results are published on entry to the idle time; rate_fix_value takes the rate result at the end of odd cycles
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         offset_fix_value <= '0;
         rate_fix_value   <= '0;
         rate_pending_r   <= '0;
         even_mid_r       <= '0;
         even_have_r      <= 1'b0;
         offset_ready     <= 1'b0;
         rate_ready       <= 1'b0;
         sync_result      <= CTS_RES_WITHIN;
      end
      else if (!run_r)
      begin
         offset_fix_value <= '0; // see [RQ21]
         rate_fix_value   <= '0;
         rate_pending_r   <= '0;
         even_have_r      <= 1'b0;
         offset_ready     <= 1'b0;
         rate_ready       <= 1'b0;
      end
      else
      begin
         offset_ready <= nit_now; // see [RQ14]
         rate_ready   <= nit_now && odd; // see [RQ17]
         if (tick_now && last && odd)
            rate_fix_value <= rate_pending_r; // see [RQ17]
         if (nit_now)
         begin
            // out-of-bound terms are reported and not applied
            offset_fix_value <= (have_r && !off_bad) ? off_calc : '0; // see [RQ13]
            if (!odd)
            begin
               even_mid_r  <= mid;
               even_have_r <= have_r;
            end
            else if (have_r && even_have_r && !rate_bad)
               rate_pending_r <= rate_calc; // see [RQ16]
            if (!have_r || (odd && !even_have_r))
               sync_result <= CTS_RES_MISSING;
            else if (off_bad || (odd && rate_bad))
               sync_result <= CTS_RES_EXCEEDS;
            else
               sync_result <= CTS_RES_WITHIN;
         end
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   a_cycle_inc: assert property (cycle_start && $past(cycle_count) != cycle_count_limit_r // [RQ1]
      |-> cycle_count == CW'($past(cycle_count) + 1'b1))
      else $error("cycle count did not step by one");
   a_cycle_wrap: assert property (cycle_start && $past(cycle_count) == cycle_count_limit_r // [RQ2]
      |-> cycle_count == '0)
      else $error("cycle count did not wrap");
   a_macro_range: assert property (macro_tick && $stable(macros_in_cycle_r) // [RQ3]
      |-> macro_count < macros_in_cycle_r)
      else $error("macro count out of range");
   a_atomic_step: assert property (run_r && $past(run_r) && $changed(cycle_count) // [RQ4]
      |-> cycle_start && macro_count == '0)
      else $error("cycle count moved without macro reset");
   a_time_read: assert property (reg_rd && reg_addr == CTS_REG_TIME // [RQ5]
      |=> reg_rdata[MW-1:0] == $past(macro_count) && reg_rdata[CTS_TIME_CYC_LSB +: CW] == $past(cycle_count))
      else $error("time word mismatch");
   a_tick_micro: assert property (macro_tick |-> $past(micro_tick)) // [RQ6]
      else $error("macrotick without microtick");
   a_presc_gap: assert property (presc_r != '0 && micro_tick |=> !micro_tick) // [RQ7]
      else $error("prescaler gap missing");
   a_offset_window: assert property (ofs_left_r != '0 // [RQ11]
      |-> cycle_count[0] && macro_count >= offset_fix_start_r)
      else $error("offset applied outside odd idle time");
   a_offset_stall: assert property (ofs_left_r > 0 && micro_tick |=> !macro_tick) // [RQ12]
      else $error("stretch did not stall macroticks");
   a_offset_ready: assert property (offset_ready |-> macro_count == nit_start_r) // [RQ14]
      else $error("offset result outside idle start");
   a_rate_ready: assert property (rate_ready |-> offset_ready && cycle_count[0]) // [RQ16]
      else $error("rate result outside odd cycle");
   a_rate_even: assert property (run_r && $past(run_r) && $changed(rate_fix_value) // [RQ17]
      |-> cycle_start && !cycle_count[0])
      else $error("rate changed outside even cycle start");

   c_cycle_wrap: cover property (cycle_start && cycle_count == '0);
   c_offset_on: cover property (ofs_left_r != '0 ##1 ofs_left_r == '0);
   c_rate_done: cover property (rate_ready && sync_result == CTS_RES_WITHIN);
endmodule

// ### dv/cts_dev_source.sv
// far-side model: sync frames of other nodes seen as deviation samples
`timescale 1ns/1ps
module cts_dev_source
   import cts_pkg::*;
(
   input  wire logic                     ref_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     cycle_start,
   input  wire logic [CTS_CW-1:0]        cycle_count,
   input  wire logic [7:0]               lag,
   input  wire logic signed [CTS_DW-1:0] dev_even,
   input  wire logic signed [CTS_DW-1:0] dev_odd,
   output logic                          dev_valid,
   output logic signed [CTS_DW-1:0]      dev_value
);
   logic [7:0] wait_r;
   logic       armed_r;

   // one sample per cycle, tied to the cycle shared by all nodes
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         armed_r <= 1'b0;
      else if (cycle_start)
         armed_r <= 1'b1;
      else if (wait_r == 8'h00)
         armed_r <= 1'b0;
   end

   // lag lets the sample come promptly or late in the cycle
   always_ff @(posedge ref_clk)
   begin
      wait_r <= cycle_start ? lag : wait_r - 8'h01;
   end

   // deviation in microticks, taken the same way on every node
   // between samples the value keeps toggling, so a stale one never looks valid
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dev_valid <= 1'b0;
         dev_value <= '0;
      end
      else
      begin
         dev_valid <= armed_r && wait_r == 8'h00;
         dev_value <= (armed_r && wait_r == 8'h00) ?
                      (cycle_count[0] ? dev_odd : dev_even) : ~dev_value;
      end
   end
endmodule

// ### dv/test_cluster_timebase_sync.sv
// self-checking bench of the cluster time base
`timescale 1ns/1ps
module test_cluster_timebase_sync
   import cts_pkg::*;
;
   localparam int MAC = 8;
   localparam int MIC = 44;
   localparam int NETWORK_IDLE_TIME = 5;
   logic                     ref_clk, sys_rst, reg_wr, reg_rd, dev_valid;
   logic [7:0]               reg_addr, lag;
   logic [31:0]              reg_wdata, reg_rdata, rd_d, rng;
   logic signed [CTS_DW-1:0] dev_value, dev_e, dev_o;
   logic                     micro_tick, macro_tick, cycle_start, offset_ready, rate_ready;
   logic [CTS_CW-1:0]        cycle_count;
   logic [CTS_MW-1:0]        macro_count;
   logic [1:0]               sync_result;
   int                       n_errors, checks_done, lim;

   cts_timebase DUT (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .dev_valid, .dev_value, .micro_tick, .macro_tick, .cycle_start, .cycle_count,
      .macro_count, .offset_ready, .rate_ready, .sync_result);

   cts_dev_source far (.ref_clk, .sys_rst, .cycle_start, .cycle_count, .lag,
      .dev_even(dev_e), .dev_odd(dev_o), .dev_valid, .dev_value);

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // include mode adds the own clock as a zero deviation
   function automatic int mid_of(int d, cts_mode_e m);
      return (m == CTS_MODE_INCLUDE) ? d / 2 : d;
   endfunction

   function automatic int cyc_len(int rate, int off, bit odd, int p);
      return (MIC + rate + (odd ? off : 0)) * (p + 1);
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask

   // runs eight whole cycles and checks every boundary against the bench model
   task automatic run_scn(input cts_mode_e m, input int p);
      int clk_n = 0, mt_n = 0, ut_n = 0, ucl = 0, k = 0, guard = 0, mmax = 0;
      int rate = 0, rate_p = 0, off = 0, mid = 0, mid_e = 0, q = 0;
      bit useen = 0;
      logic [1:0] res;
      logic [31:0] t0, t1;
      wr(CTS_REG_CTRL, {16'h0, 8'(p), 5'h0, m, 1'b1});
      while (k < 8)
      begin
         @(negedge ref_clk);
         guard++;
         clk_n++;
         if (guard > 6000)
         begin
            n_errors++;
            summarize();
         end
         if (micro_tick)
         begin
            if (useen) chk("micro_gap", p + 1, ucl);
            ucl = 0;
            useen = 1;
         end
         ucl++;
         if (macro_tick)
         begin
            q = (MIC + rate) / MAC;
            if (k >= 2 && !k[0]) chk("macro_len", 1, 32'(ut_n == q || ut_n == q + 1));
            ut_n = 0;
            mt_n++;
         end
         if (micro_tick) ut_n++;
         if (int'(macro_count) > mmax) mmax = int'(macro_count);
         if (offset_ready)
         begin
            chk("idle_entry", NETWORK_IDLE_TIME, 32'(macro_count));
            chk("rate_ready", 32'(k[0]), 32'(rate_ready));
            mid = mid_of(k[0] ? dev_o : dev_e, m);
            off = (k == 0) ? 0 : -mid;
            if (off > lim || off < -lim) off = 0;
            // the first odd cycle has no even partner yet, so its rate term is missing
            res = (k <= 1) ? CTS_RES_MISSING : (off == 0) ? CTS_RES_EXCEEDS : CTS_RES_WITHIN;
            chk("result", 32'(res), 32'(sync_result));
            if (k[0] && k > 1) rate_p = rate - (mid - mid_e);
            if (!k[0]) mid_e = mid;
         end
         else chk("rate_quiet", 0, 32'(rate_ready));
         if (cycle_start)
         begin
            if (k > 0)
            begin
               chk("cycle_len", cyc_len(rate, off, k[0], p), clk_n);
               chk("macros", MAC, mt_n);
               chk("macro_max", MAC - 1, mmax);
            end
            k++;
            chk("cycle_count", k % 4, 32'(cycle_count));
            chk("macro_zero", 0, 32'(macro_count));
            if (!k[0]) rate = rate_p;
            clk_n = 0;
            mt_n = 0;
            mmax = 0;
         end
      end
      rd(CTS_REG_FIX, rd_d);
      chk("fix", {16'(rate), 16'(off)}, rd_d);
      t0 = {10'h0, cycle_count, 2'h0, macro_count};
      rd(CTS_REG_TIME, rd_d);
      t1 = {10'h0, cycle_count, 2'h0, macro_count};
      chk("time", (rd_d === t0) ? t0 : t1, rd_d);
      wr(CTS_REG_CTRL, 32'h0);
      repeat (2) @(negedge ref_clk);
      chk("stopped", 0, 32'({cycle_count, macro_count}));
      rd(CTS_REG_FIX, rd_d);
      chk("fix_clear", 0, rd_d);
      rd(CTS_REG_MICRO, rd_d);
      chk("micro_clear", 0, rd_d);
   endtask

   initial
   begin
      logic [7:0]  ra [9];
      logic [31:0] rv [9];
      cts_mode_e   md;
      rng = 32'h0000510e;
      n_errors = 0;
      checks_done = 0;
      sys_rst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata, lag, dev_e, dev_o} = '0;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      chk("reset_out", 0, 32'({micro_tick, macro_tick, cycle_start, cycle_count,
          macro_count, offset_ready, rate_ready, sync_result}));
      ra = '{CTS_REG_CTRL, CTS_REG_CYCMAX, CTS_REG_MACROS, CTS_REG_MICROS, CTS_REG_OFSSTA,
             CTS_REG_NITSTA, CTS_REG_OFSLIM, CTS_REG_RATLIM, 8'h30};
      rv = '{32'h0, 32'(CTS_CYCMAX_RST), 32'(CTS_MACROS_RST), 32'(CTS_MICROS_RST),
             32'(CTS_OFSSTA_RST), 32'(CTS_NITSTA_RST), 32'(CTS_LIMIT_RST),
             32'(CTS_LIMIT_RST), 32'h0};
      // the unmapped word must stay zero after a write
      wr(8'h30, 32'hffffffff);
      for (int i = 0; i < 9; i++)
      begin
         rd(ra[i], rd_d);
         chk("reg_reset", rv[i], rd_d);
      end
      wr(CTS_REG_CYCMAX, 32'h3);
      wr(CTS_REG_MACROS, MAC);
      wr(CTS_REG_MICROS, MIC);
      wr(CTS_REG_NITSTA, NETWORK_IDLE_TIME);
      wr(CTS_REG_OFSSTA, 32'h6);
      lim = 64;
      // deviations kept small so the corrected cycle stays above twice the macro count
      for (int s = 0; s < 3; s++)
      begin
         md = (s == 1) ? CTS_MODE_INCLUDE : CTS_MODE_EXCLUDE;
         lag <= 8'(rnd() % 16);
         if (s == 2)
         begin
            lim = 3;
            wr(CTS_REG_OFSLIM, 32'h3);
            dev_e <= -16'sd8;
            dev_o <= -16'sd8;
         end
         else
         begin
            dev_e <= -16'(2 + 2 * (rnd() % 5));
            dev_o <= -16'(2 + 2 * (rnd() % 5));
         end
         run_scn(md, int'(rnd() % 3));
      end
      summarize();
   end
endmodule
